// file: rtl/adcc_pkg.sv
// Constants shared by the converter control block.
// Assumes a single 50 MHz peripheral clock and an Avalon-MM host.
package adcc_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [3:0] IDX_CTRL   = 4'h0;  // Enable, reset, start, modes
  localparam logic [3:0] IDX_CLKDIV = 4'h1;  // clock_divider_control
  localparam logic [3:0] IDX_REF    = 4'h2;  // reference_control
  localparam logic [3:0] IDX_INSEL  = 4'h3;  // Positive and negative input select
  localparam logic [3:0] IDX_GAIN   = 4'h4;  // gain_correction_value
  localparam logic [3:0] IDX_OFFS   = 4'h5;  // offset_correction_value
  localparam logic [3:0] IDX_STAT   = 4'h6;  // Status, read only
  localparam logic [3:0] IDX_RES    = 4'h7;  // Result, read only
  localparam logic [3:0] IDX_AVG    = 4'hc;  // averaging_control
  // Control register bit positions
  localparam int B_ENABLE = 0;
  localparam int B_SWRST  = 1;
  localparam int B_START  = 2;
  localparam int B_FOLLOW = 3;
  localparam int B_FREE   = 4;
  localparam int B_LEFT   = 5;
  localparam int B_DIFF   = 6;
  localparam int B_CORR   = 7;
  // Field positions
  localparam int B_REF_BUFFER_OFFSET_COMP = 7;   // Offset compensation enable
  localparam int B_NEGSEL  = 8;   // Negative select starts here
  localparam int B_SHIFT   = 4;   // average_shift starts here
  // Status bit positions
  localparam int B_RBUSY = 0;
  localparam int B_CBUSY = 1;
  localparam int B_SBUSY = 2;
  // Reset values
  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [2:0]  RST_DIV   = 3'h0;
  localparam logic [7:0]  RST_REF   = 8'h00;
  localparam logic [15:0] RST_INSEL = 16'h0000;
  localparam logic [11:0] RST_GAIN  = 12'h800;  // Unity gain, 1.11 format
  localparam logic [11:0] RST_OFFS  = 12'h000;
  localparam logic [6:0]  RST_AVG   = 7'h00;
  // Timing counts in converter clock ticks or peripheral cycles, and the log2 averaging limit
  localparam logic [4:0]  CONV_TICKS  = 5'd12;  // One plain conversion
  localparam logic [4:0]  CORR_EXTRA  = 5'd13;  // Added with correction
  localparam logic [1:0]  SWRST_CYC   = 2'd3;   // Soft reset countdown load; busy stays high for 4 cycles
  localparam logic [3:0]  MAX_ACC     = 4'ha;   // 1024 samples at most
  // Converter sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } adcc_state_t;
endpackage : adcc_pkg

// file: rtl/adcc_top.sv
// Control and configuration logic of a successive-approximation converter.
// Assumes inputs synchronous to ref_clk_i and an Avalon-MM master with
// byte addressing; the analog sampler delivers codes on pos/neg inputs.
//
// The implementer's own choice: the Avalon-MM register port.
module adcc_top (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        peripheral_access_guard_i,
  input  wire logic        leader_tick_i,
  input  wire logic [11:0] pos_code_i,
  input  wire logic [11:0] neg_code_i,
  output logic             adc_clk_o,
  output logic [4:0]       positive_input_select_o,
  output logic [4:0]       negative_input_select_o,
  output logic             differential_input_o,
  output logic [3:0]       reference_select_o,
  output logic             ref_buffer_offset_comp_o,
  output logic [15:0]      result_o,
  output logic             result_valid_o
);
  logic [7:0]        ctrl_reg;       // Control bits
  logic [2:0]        div_reg;        // Divider select
  logic [7:0]        ref_reg;        // Reference select and compensation
  logic [15:0]       insel_reg;      // Input selection fields
  logic [11:0]       gain_reg;       // Gain correction, 1.11 format
  logic [11:0]       offs_reg;       // Offset correction, two's complement
  logic [6:0]        avg_shadow_reg; // Bus-side averaging value
  logic [6:0]        avg_reg;        // Converter-side averaging value
  logic              avg_pend_reg;   // Averaging write not yet applied
  logic [1:0]        rst_cnt_reg;    // Soft reset countdown
  logic              rbusy_reg;      // Soft reset in progress
  logic [7:0]        div_cnt_reg;    // Free-running prescaler
  logic              tick_reg;       // Converter clock enable pulse
  adcc_pkg::adcc_state_t state_reg;  // Sequencer state
  logic [4:0]        conv_cnt_reg;   // Ticks within a conversion
  logic [21:0]       acc_reg;        // Sample accumulator
  logic [10:0]       acc_n_reg;      // Samples summed so far
  logic              start_pend_reg; // Start requested by software
  logic              acc_ok;         // Bus access completes this cycle
  logic              wr_ok;          // Register write completes
  logic [3:0]        idx;            // Word index from byte address
  logic              prot_ok;        // Enable-protected write allowed
  logic [7:0]        tick_mask;      // Prescaler terminal mask
  logic [11:0]       raw_code;       // Sample before correction
  logic signed [26:0] corr_prod;     // Gain times offset-removed sample
  logic [11:0]       samp;           // Sample after correction
  logic [10:0]       acc_target;     // Samples per result
  logic [21:0]       acc_sum;        // Accumulator including this sample
  logic [21:0]       shifted;        // Sum after division
  logic [4:0]        conv_len;       // Ticks per conversion

  assign idx     = avs_address_i[5:2];
  assign acc_ok  = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  assign wr_ok   = acc_ok && avs_write_i && !rbusy_reg;
  // Guard blocks all writes; enable protection only certain registers
  assign prot_ok = !peripheral_access_guard_i && !ctrl_reg[adcc_pkg::B_ENABLE];

  // Byte-lane merge so partial writes keep untouched lanes
  function automatic logic [15:0] merge16(input logic [15:0] old_v);
    merge16 = old_v;
    if (avs_byteenable_i[0])
      merge16[7:0] = avs_writedata_i[7:0];
    if (avs_byteenable_i[1])
      merge16[15:8] = avs_writedata_i[15:8];
  endfunction : merge16

  // Wait state generator: one wait cycle, then answer for one cycle
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      avs_waitrequest_o <= 1'b1;
    else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  // Read data captured alongside the falling waitrequest
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && avs_waitrequest_o)
    begin
      case (idx)
        adcc_pkg::IDX_CTRL:   avs_readdata_o <= {24'h0, ctrl_reg};
        adcc_pkg::IDX_CLKDIV: avs_readdata_o <= {29'h0, div_reg};
        adcc_pkg::IDX_REF:    avs_readdata_o <= {24'h0, ref_reg};
        adcc_pkg::IDX_INSEL:  avs_readdata_o <= {16'h0, insel_reg};
        adcc_pkg::IDX_GAIN:   avs_readdata_o <= {20'h0, gain_reg};
        adcc_pkg::IDX_OFFS:   avs_readdata_o <= {20'h0, offs_reg};
        adcc_pkg::IDX_STAT:   avs_readdata_o <= {29'h0, avg_pend_reg,
                                                 state_reg != adcc_pkg::ST_IDLE,
                                                 rbusy_reg};
        adcc_pkg::IDX_RES:    avs_readdata_o <= {16'h0, result_o};
        adcc_pkg::IDX_AVG:    avs_readdata_o <= {25'h0, avg_shadow_reg};
        default:              avs_readdata_o <= 32'h0000_0000; // Unmapped
      endcase
    end
  end

  // Soft reset countdown; busy flag visible while it runs
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_cnt_reg <= 2'd0;
      rbusy_reg   <= 1'b0;
    end
    else if (wr_ok && idx == adcc_pkg::IDX_CTRL && avs_writedata_i[adcc_pkg::B_SWRST]
             && avs_byteenable_i[0] && !peripheral_access_guard_i)
    begin
      rst_cnt_reg <= adcc_pkg::SWRST_CYC;
      rbusy_reg   <= 1'b1;
    end
    else if (rst_cnt_reg != 2'd0)
      rst_cnt_reg <= rst_cnt_reg - 2'd1;
    else
      rbusy_reg <= 1'b0;
  end

  // Control register; start and reset bits are strobes, not stored
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl_reg <= adcc_pkg::RST_CTRL;
    else if (rbusy_reg)
      ctrl_reg <= adcc_pkg::RST_CTRL;
    else if (wr_ok && idx == adcc_pkg::IDX_CTRL && avs_byteenable_i[0]
             && !peripheral_access_guard_i)
    begin
      ctrl_reg <= avs_writedata_i[7:0];
      ctrl_reg[adcc_pkg::B_SWRST] <= 1'b0;
      ctrl_reg[adcc_pkg::B_START] <= 1'b0;
    end
  end

  // Enable-protected configuration registers
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_reg   <= adcc_pkg::RST_DIV;
      ref_reg   <= adcc_pkg::RST_REF;
      insel_reg <= adcc_pkg::RST_INSEL;
      gain_reg  <= adcc_pkg::RST_GAIN;
      offs_reg  <= adcc_pkg::RST_OFFS;
    end
    else if (rbusy_reg)
    begin
      div_reg   <= adcc_pkg::RST_DIV;
      ref_reg   <= adcc_pkg::RST_REF;
      insel_reg <= adcc_pkg::RST_INSEL;
      gain_reg  <= adcc_pkg::RST_GAIN;
      offs_reg  <= adcc_pkg::RST_OFFS;
    end
    else if (wr_ok && prot_ok)
    begin
      case (idx)
        adcc_pkg::IDX_CLKDIV:
          if (avs_byteenable_i[0])
            div_reg <= avs_writedata_i[2:0];
        adcc_pkg::IDX_REF:
          if (avs_byteenable_i[0])
            ref_reg <= avs_writedata_i[7:0] & 8'h8f;
        adcc_pkg::IDX_INSEL: insel_reg <= merge16(insel_reg) & 16'h1f1f;
        adcc_pkg::IDX_GAIN:  gain_reg  <= 12'(merge16({4'h0, gain_reg}));
        adcc_pkg::IDX_OFFS:  offs_reg  <= 12'(merge16({4'h0, offs_reg}));
        default:             div_reg   <= div_reg;
      endcase
    end
  end

  // Averaging: bus copy, then applied on a converter tick
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      avg_shadow_reg <= adcc_pkg::RST_AVG;
      avg_reg        <= adcc_pkg::RST_AVG;
      avg_pend_reg   <= 1'b0;
    end
    else if (rbusy_reg)
    begin
      avg_shadow_reg <= adcc_pkg::RST_AVG;
      avg_reg        <= adcc_pkg::RST_AVG;
      avg_pend_reg   <= 1'b0;
    end
    else
    begin
      // A new write in the same cycle as the apply keeps pending set
      if (tick_reg && avg_pend_reg)
      begin
        avg_reg      <= avg_shadow_reg;
        avg_pend_reg <= 1'b0;
      end
      if (wr_ok && idx == adcc_pkg::IDX_AVG && avs_byteenable_i[0]
          && !peripheral_access_guard_i)
      begin
        avg_shadow_reg <= avs_writedata_i[6:0];
        avg_pend_reg   <= 1'b1;
      end
    end
  end

  // Terminal mask of 2^(sel+1)-1 for the chosen division
  assign tick_mask = 8'((9'h002 << div_reg) - 9'h001);

  // Prescaler runs free; no sync needed as it shares the clock
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_cnt_reg <= 8'h00;
      tick_reg    <= 1'b0;
      adc_clk_o   <= 1'b0;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
      if (ctrl_reg[adcc_pkg::B_FOLLOW])
        tick_reg <= leader_tick_i;
      else
        tick_reg <= (div_cnt_reg & tick_mask) == tick_mask;
      adc_clk_o <= div_cnt_reg[div_reg];
    end
  end

  // Sample path: differential folded to offset binary
  assign raw_code = ctrl_reg[adcc_pkg::B_DIFF]
                  ? 12'(({1'b0, pos_code_i} - {1'b0, neg_code_i} + 13'h1000) >> 1)
                  : pos_code_i;
  assign corr_prod = ($signed({2'b00, raw_code}) - $signed({{2{offs_reg[11]}}, offs_reg}))
                   * $signed({1'b0, gain_reg});
  always_comb
  begin
    samp = raw_code;
    if (ctrl_reg[adcc_pkg::B_CORR])
    begin
      if (corr_prod < 0)
        samp = 12'h000;
      else if (corr_prod[26:11] > 16'h0fff)
        samp = 12'hfff;
      else
        samp = corr_prod[22:11];
    end
  end

  // Accumulation target and division
  assign acc_target = (avg_reg[3:0] > adcc_pkg::MAX_ACC)
                    ? 11'h400 : 11'(11'h001 << avg_reg[3:0]);
  assign acc_sum    = acc_reg + {10'h000, samp};
  assign shifted    = acc_sum >> avg_reg[6:adcc_pkg::B_SHIFT];
  assign conv_len   = ctrl_reg[adcc_pkg::B_CORR]
                    ? adcc_pkg::CONV_TICKS + adcc_pkg::CORR_EXTRA
                    : adcc_pkg::CONV_TICKS;

  // Start strobe held until the sequencer takes it
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      start_pend_reg <= 1'b0;
    else if (wr_ok && idx == adcc_pkg::IDX_CTRL && avs_byteenable_i[0]
             && avs_writedata_i[adcc_pkg::B_START] && !peripheral_access_guard_i)
      start_pend_reg <= 1'b1;
    else if (state_reg == adcc_pkg::ST_CONV || !ctrl_reg[adcc_pkg::B_ENABLE])
      start_pend_reg <= 1'b0;
  end

  // Conversion sequencer
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg      <= adcc_pkg::ST_IDLE;
      conv_cnt_reg   <= 5'd0;
      acc_reg        <= 22'h0;
      acc_n_reg      <= 11'h0;
      result_o       <= 16'h0000;
      result_valid_o <= 1'b0;
    end
    else if (rbusy_reg || !ctrl_reg[adcc_pkg::B_ENABLE])
    begin
      state_reg      <= adcc_pkg::ST_IDLE;
      conv_cnt_reg   <= 5'd0;
      acc_reg        <= 22'h0;
      acc_n_reg      <= 11'h0;
      result_valid_o <= 1'b0;
      if (rbusy_reg)
        result_o <= 16'h0000;
    end
    else
    begin
      result_valid_o <= 1'b0;
      case (state_reg)
        adcc_pkg::ST_IDLE:
          if (start_pend_reg || ctrl_reg[adcc_pkg::B_FREE])
          begin
            state_reg    <= adcc_pkg::ST_CONV;
            conv_cnt_reg <= 5'd0;
          end
        adcc_pkg::ST_CONV:
          if (tick_reg)
          begin
            if (conv_cnt_reg == conv_len - 5'd1)
            begin
              conv_cnt_reg <= 5'd0;
              if (acc_n_reg + 11'h001 >= acc_target)
              begin
                acc_reg   <= 22'h0;
                acc_n_reg <= 11'h0;
                state_reg <= adcc_pkg::ST_DONE;
                result_valid_o <= 1'b1;
                if (acc_target == 11'h001 && avg_reg[6:4] == 3'h0
                    && ctrl_reg[adcc_pkg::B_LEFT])
                  result_o <= {samp, 4'h0};
                else
                  result_o <= shifted[15:0];
              end
              else
              begin
                acc_reg   <= acc_sum;
                acc_n_reg <= acc_n_reg + 11'h001;
              end
            end
            else
              conv_cnt_reg <= conv_cnt_reg + 5'd1;
          end
        adcc_pkg::ST_DONE:
          // Continuous mode goes straight into the next conversion
          if (ctrl_reg[adcc_pkg::B_FREE])
            state_reg <= adcc_pkg::ST_CONV;
          else
            state_reg <= adcc_pkg::ST_IDLE;
        default:
          state_reg <= adcc_pkg::ST_IDLE;
      endcase
    end
  end

  // Analog routing registered from configuration flops
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      positive_input_select_o  <= 5'h00;
      negative_input_select_o  <= 5'h00;
      differential_input_o     <= 1'b0;
      reference_select_o       <= 4'h0;
      ref_buffer_offset_comp_o <= 1'b0;
    end
    else
    begin
      positive_input_select_o  <= insel_reg[4:0];
      negative_input_select_o  <= insel_reg[adcc_pkg::B_NEGSEL +: 5];
      differential_input_o     <= ctrl_reg[adcc_pkg::B_DIFF];
      reference_select_o       <= ref_reg[3:0];
      ref_buffer_offset_comp_o <= ref_reg[adcc_pkg::B_REF_BUFFER_OFFSET_COMP];
    end
  end

  // Checks
  sequence div_wr_s;
    wr_ok && idx == adcc_pkg::IDX_CLKDIV && avs_byteenable_i[0];
  endsequence
  div_period_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    tick_reg && div_reg == 3'h0 && !ctrl_reg[adcc_pkg::B_FOLLOW]
    && !$past(ctrl_reg[adcc_pkg::B_FOLLOW])
    |=> !tick_reg ##1 (tick_reg || $past(div_reg) != 3'h0 || $past(ctrl_reg[adcc_pkg::B_FOLLOW])))
    else $error("prescaler tick spacing wrong");
  follow_tick_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_reg[adcc_pkg::B_FOLLOW] |=> tick_reg == $past(leader_tick_i))
    else $error("follower tick not from leader");
  div_protect_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    div_wr_s and ##0 (ctrl_reg[adcc_pkg::B_ENABLE] || peripheral_access_guard_i)
    |=> $stable(div_reg))
    else $error("protected divider changed");
  ref_fields_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ref_reg[6:4] == 3'h0 ##1 1'b1 |-> ref_buffer_offset_comp_o == $past(ref_reg[7]))
    else $error("reference output mismatch");
  corr_len_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    state_reg == adcc_pkg::ST_CONV |-> conv_cnt_reg
      < (ctrl_reg[adcc_pkg::B_CORR] ? 5'd25 : 5'd12))
    else $error("conversion length out of range");
  single_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    state_reg == adcc_pkg::ST_DONE && !ctrl_reg[adcc_pkg::B_FREE]
    && ctrl_reg[adcc_pkg::B_ENABLE] && !rbusy_reg |=> state_reg == adcc_pkg::ST_IDLE)
    else $error("single conversion did not stop");
  left_align_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    result_valid_o && $past(ctrl_reg[adcc_pkg::B_LEFT]) && $past(avg_reg) == 7'h00
    |-> result_o[3:0] == 4'h0)
    else $error("left aligned result has low bits");
  avg_sync_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    avg_pend_reg && !tick_reg |=> $stable(avg_reg) || $past(rbusy_reg))
    else $error("averaging applied without tick");
  rbusy_len_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(rbusy_reg) |-> rbusy_reg [*4] ##1 (!rbusy_reg || $past(wr_ok)))
    else $error("reset busy length wrong");
endmodule : adcc_top

// file: testbench/adc_control_config_test.sv
// Self-checking bench for the converter control block.
// Assumes adcc_top answers Avalon-MM with one wait cycle, 50 MHz clock.
module adc_control_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 1'b0;  // Peripheral clock
  logic        rstn_i    = 1'b0;  // Reset, active low
  logic [5:0]  addr      = 6'h00; // Byte address
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic        guard     = 1'b0;  // Write block
  logic        ltick     = 1'b0;  // Leader tick for follower mode
  logic [11:0] pos       = 12'h0; // Analog model codes
  logic [11:0] neg       = 12'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic        adc_clk;
  logic [4:0]  psel;
  logic [4:0]  nsel;
  logic        diff;
  logic [3:0]  rsel;
  logic        rcomp;
  logic [15:0] result;
  logic        rvalid;
  logic [31:0] got;              // Last read data
  logic [15:0] res;              // Last result
  int          mismatches = 0;
  int          checks     = 0;
  int          cycles     = 0;
  int          n;

  adcc_top dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'h3), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .peripheral_access_guard_i(guard), .leader_tick_i(ltick), .pos_code_i(pos),
    .neg_code_i(neg), .adc_clk_o(adc_clk), .positive_input_select_o(psel),
    .negative_input_select_o(nsel), .differential_input_o(diff),
    .reference_select_o(rsel), .ref_buffer_offset_comp_o(rcomp),
    .result_o(result), .result_valid_o(rvalid));

  // Clock, 20 ns period
  always #10 ref_clk_i = ~ref_clk_i;

  // Hang guard; a full run needs well under 5000 cycles
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr  <= {idx, 2'b00};
    wr    <= w;
    rd    <= ~w;
    wdata <= d;
    @(posedge ref_clk_i);
    while (wait_req !== 1'b0)
      @(posedge ref_clk_i);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  // Enable, then start; wait a bounded time for the result pulse
  task automatic convert(input logic [7:0] mode);
    bus(1'b1, adcc_pkg::IDX_CTRL, {24'h0, mode | 8'h01});
    bus(1'b1, adcc_pkg::IDX_CTRL, {24'h0, mode | 8'h05});
    n = 0;
    @(posedge ref_clk_i);
    while (rvalid !== 1'b1 && n < 2000)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    res = result;
  endtask : convert

  // Result pulses seen over a window
  task automatic pulses(input int len);
    n = 0;
    repeat (len)
    begin
      @(posedge ref_clk_i);
      if (rvalid === 1'b1)
        n++;
    end
  endtask : pulses

  task automatic t_regs();
    bus(1'b0, adcc_pkg::IDX_CLKDIV, 0);
    chk("clkdiv reset", 32'h0, got);
    bus(1'b0, adcc_pkg::IDX_AVG, 0);
    chk("avg reset", 32'h0, got);
    bus(1'b1, adcc_pkg::IDX_REF, 32'h8f);
    bus(1'b1, adcc_pkg::IDX_INSEL, 32'h0305);
    repeat (2) @(posedge ref_clk_i);
    chk("ref select", 32'hf, rsel);
    chk("ref comp", 32'h1, rcomp);
    chk("pos select", 32'h5, psel);
    chk("neg select", 32'h3, nsel);
    guard <= 1'b1;
    bus(1'b1, adcc_pkg::IDX_REF, 32'h00);
    bus(1'b1, adcc_pkg::IDX_AVG, 32'h11);
    guard <= 1'b0;
    bus(1'b0, adcc_pkg::IDX_REF, 0);
    chk("guarded ref", 32'h8f, got);
    bus(1'b0, adcc_pkg::IDX_AVG, 0);
    chk("guarded avg", 32'h0, got);
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h01);
    bus(1'b1, adcc_pkg::IDX_CLKDIV, 32'h3);
    bus(1'b0, adcc_pkg::IDX_CLKDIV, 0);
    chk("enabled clkdiv", 32'h0, got);
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h00);
    $display("test regs done");
  endtask : t_regs

  // High time of the divided clock after a rise, for every divider code
  task automatic t_div();
    int p;
    for (int s = 0; s < 8; s++)
    begin
      bus(1'b1, adcc_pkg::IDX_CLKDIV, s);
      repeat (2) @(posedge ref_clk_i);
      for (int k = 0; k < 2; k++)
      begin
        p = 0;
        @(posedge ref_clk_i);
        while (adc_clk !== 1'b0 && p < 600)
        begin
          @(posedge ref_clk_i);
          p++;
        end
        p = 1;
        @(posedge ref_clk_i);
        while (adc_clk !== 1'b1 && p < 600)
        begin
          @(posedge ref_clk_i);
          p++;
        end
      end
      p = 0;
      while (adc_clk !== 1'b0 && p < 600)
      begin
        @(posedge ref_clk_i);
        p++;
      end
      chk("divided half period", 2 ** s, p);
    end
    bus(1'b1, adcc_pkg::IDX_CLKDIV, 0);
    $display("test div done");
  endtask : t_div

  // Follower: divider ignored, leader ticks pace the conversion
  task automatic t_follow();
    pos <= 12'h0ab;
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h09);
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h0d);
    pulses(100);
    chk("follower without leader", 32'h0, n);
    bus(1'b0, adcc_pkg::IDX_STAT, 0);
    chk("follower stalled busy", 32'h1, got[1]);
    ltick <= 1'b1;
    pulses(40);
    chk("follower with leader", 32'h1, n);
    chk("follower result", 32'h0ab, result);
    ltick <= 1'b0;
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h00);
    $display("test follow done");
  endtask : t_follow

  task automatic t_conv();
    pos <= 12'h123;
    neg <= 12'h023;
    convert(8'h00);
    chk("single result", 32'h0123, res);
    pulses(150);
    chk("single no repeat", 32'h0, n);
    convert(8'h20);
    chk("left aligned", 32'h1230, res);
    convert(8'h40);
    chk("differential", 32'h0880, res);
    chk("differential route", 32'h1, diff);
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h00);
    bus(1'b1, adcc_pkg::IDX_OFFS, 32'h023);
    convert(8'h80);
    chk("corrected", 32'h0100, res);
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h00);
    bus(1'b1, adcc_pkg::IDX_OFFS, 32'h0);
    convert(8'h10);
    pulses(200);
    chk("continuous repeats", 32'h1, 32'(n > 2));
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h00);
    pos <= 12'h100;
    bus(1'b1, adcc_pkg::IDX_AVG, 32'h21);
    bus(1'b0, adcc_pkg::IDX_AVG, 0);
    chk("avg readback", 32'h21, got);
    convert(8'h10);
    chk("averaged", 32'h0080, res);
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h00);
    $display("test conv done");
  endtask : t_conv

  task automatic t_swrst();
    bus(1'b1, adcc_pkg::IDX_CTRL, 32'h02);
    bus(1'b0, adcc_pkg::IDX_STAT, 0);
    chk("reset busy", 32'h1, got[0]);
    repeat (8) @(posedge ref_clk_i);
    bus(1'b0, adcc_pkg::IDX_STAT, 0);
    chk("reset idle", 32'h0, got[0]);
    bus(1'b0, adcc_pkg::IDX_REF, 0);
    chk("ref after reset", 32'h0, got);
    $display("test swrst done");
  endtask : t_swrst

  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_div();
    t_follow();
    t_conv();
    t_swrst();
    conclude();
  end
endmodule : adc_control_config_test
